// File: include/dpt_pkg.sv
package dpt_pkg;
    // Byte address of a register is four times its index
    localparam int ADR_W = 18;
    localparam logic [15:0] IDX_SHARED = 16'hFF30;
    localparam logic [15:0] IDX_T0CTL = 16'hFF31;
    localparam logic [15:0] IDX_T1CTL = 16'hFF32;
    localparam logic [15:0] IDX_RLD0 = 16'hFF33;
    localparam logic [15:0] IDX_RLD1 = 16'hFF34;
    localparam logic [15:0] IDX_CNT0 = 16'hFF35;
    localparam logic [15:0] IDX_CNT1 = 16'hFF36;
    localparam logic [15:0] IDX_FLAGS = 16'hFF37;
    // Shared control bits
    localparam int SH_SRC0 = 0;
    localparam int SH_SRC1 = 1;
    localparam int SH_OE = 2;
    localparam int SH_OUTPUT_CHANNEL_SELECT = 3;
    localparam int SH_CASCADE = 4;
    // Timer control bits; POL, FSEL and MODE exist in the timer0 register only
    localparam int CT_RUN = 0;
    localparam int CT_PRESET = 1;
    localparam int CT_CONT = 2;
    localparam int CT_DIV_LO = 3;
    localparam int CT_DIV_HI = 4;
    localparam int CT_POL = 5;
    localparam int CT_FSEL = 6;
    localparam int CT_MODE = 7;
    // Reset values
    localparam logic [7:0] RELOAD_RST = 8'hFF;
    localparam logic [7:0] COUNT_RST = 8'hFF;
    localparam logic [1:0] DIV_RST = 2'h0;
    // Prescaler codes and their last count
    localparam int PSC_W = 6;
    localparam logic [1:0] DIV_BY1 = 2'h0;
    localparam logic [1:0] DIV_BY4 = 2'h1;
    localparam logic [1:0] DIV_BY16 = 2'h2;
    localparam logic [5:0] PSC_LAST4 = 6'h03;
    localparam logic [5:0] PSC_LAST16 = 6'h0F;
    localparam logic [5:0] PSC_LAST64 = 6'h3F;
    // Low-speed ticks per half period of the 2,048 Hz signal
    localparam logic [3:0] LS_HALF_LAST = 4'h7;
    // Noise rejecter passes a level after two falling edges of 2,048 Hz
    localparam logic [1:0] NR_FALL_LAST = 2'h1;
    // Latch release after four half periods: 0.73 to 0.98 msec
    localparam logic [2:0] LATCH_HALF_LAST = 3'h3;
endpackage

// File: include/dpt_psc_if.sv
interface dpt_psc_if;
    logic src_tick;
    logic [1:0] ratio;
    logic clear;
    logic out_tick;
    modport psc (input src_tick, input ratio, input clear, output out_tick);
    modport ctl (output src_tick, output ratio, output clear, input out_tick);
endinterface

// File: logic/dpt_prescaler.sv
module dpt_prescaler import dpt_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    dpt_psc_if.psc bus
);
    typedef struct packed {
        logic [PSC_W-1:0] cnt;
    } dpt_psc_state_t;

    dpt_psc_state_t st_ff;
    dpt_psc_state_t nxt_st;
    logic [PSC_W-1:0] last;

    always_comb begin
        case (bus.ratio)
            DIV_BY1: last = '0;
            DIV_BY4: last = PSC_LAST4;
            DIV_BY16: last = PSC_LAST16;
            default: last = PSC_LAST64;
        endcase
        nxt_st = st_ff;
        if (bus.clear) begin
            nxt_st.cnt = '0;
        end else if (bus.src_tick) begin
            nxt_st.cnt = (st_ff.cnt >= last) ? '0 : st_ff.cnt + 6'h01;
        end
    end

    assign bus.out_tick = bus.src_tick & !bus.clear & (st_ff.cnt >= last);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // A stop or an output tick must leave the divider at the start of a fresh period
    property p_psc_clear;
        @(posedge clk_i) disable iff (rst_i) bus.clear || bus.out_tick |=> st_ff.cnt == '0;
    endproperty
    a_psc_clear: assert property (p_psc_clear) else $error("prescaler did not restart");
endmodule

// File: logic/dpt_noise_filter.sv
module dpt_noise_filter import dpt_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic fall_i,
    input wire logic raw_i,
    output logic level_o
);
    typedef struct packed {
        logic level;
        logic [1:0] edges;
    } dpt_nr_state_t;

    dpt_nr_state_t st_ff;
    dpt_nr_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (!enable_i || raw_i == st_ff.level) begin
            nxt_st.level = raw_i;
            nxt_st.edges = '0;
        end else if (fall_i) begin
            if (st_ff.edges == NR_FALL_LAST) begin
                nxt_st.level = raw_i;
                nxt_st.edges = '0;
            end else begin
                nxt_st.edges = st_ff.edges + 2'h1;
            end
        end
    end

    assign level_o = st_ff.level;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    property p_nr_hold;
        @(posedge clk_i) disable iff (rst_i)
            enable_i && !fall_i && raw_i != level_o |=> level_o == $past(level_o);
    endproperty
    a_nr_hold: assert property (p_nr_hold) else $error("filter passed level early");
endmodule

// File: logic/dpt_top.sv
// Added by the designer: the Wishbone slave port.
module dpt_top import dpt_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic low_speed_osc_clock_i,
    input wire logic high_speed_osc_clock_i,
    input wire logic event_input_i,
    output logic timer_output_port_pin_o
);
    typedef struct packed {
        logic ack;
        logic [7:0] rdat;
        logic [1:0] src_sel;
        logic oe;
        logic output_channel_select;
        logic cascade;
        logic cnt_mode;
        logic func_sel;
        logic polarity;
        logic [1:0] cont;
        logic [1:0][1:0] div;
        logic [1:0] run;
        logic [1:0][7:0] reload;
        logic [1:0][7:0] count;
        logic [1:0][7:0] readout;
        logic latched;
        logic [2:0] latch_age;
        logic [1:0] flag;
        logic timer_output_signal;
        logic pin;
        logic ev_prev;
        logic [3:0] ls_div;
        logic sig2048;
    } dpt_state_t;

    dpt_state_t st_ff;
    dpt_state_t nxt_st;

    logic req;
    logic acc;
    logic wr;
    logic rd;
    logic [15:0] idx;
    logic [7:0] wdat;
    logic [7:0] rmux;
    logic half_tick;
    logic fall2048;
    logic ev_lvl;
    logic ev_edge;
    logic level_ok;
    logic tick0;
    logic dec0;
    logic dec1;
    logic uf0;
    logic uf1;
    logic out_uf;
    logic [1:0] psc_tick;

    // Writes and read side effects happen on the edge where the master sees ack
    assign req = wb_cyc_i & wb_stb_i;
    assign acc = req & st_ff.ack;
    assign wr = acc & wb_we_i & wb_sel_i[0];
    assign rd = acc & !wb_we_i;
    assign idx = wb_adr_i[ADR_W-1:2];
    assign wdat = wb_dat_i[7:0];

    // 2,048 Hz signal from the low-speed oscillator
    assign half_tick = low_speed_osc_clock_i & (st_ff.ls_div == LS_HALF_LAST);
    assign fall2048 = half_tick & st_ff.sig2048;

    dpt_psc_if psc_bus[2] ();

    for (genvar g = 0; g < 2; g++) begin : g_psc
        assign psc_bus[g].src_tick = st_ff.src_sel[g] ? high_speed_osc_clock_i
                                                      : low_speed_osc_clock_i;
        assign psc_bus[g].ratio = st_ff.div[g];
        assign psc_bus[g].clear = !st_ff.run[g];
        assign psc_tick[g] = psc_bus[g].out_tick;
        dpt_prescaler u_psc (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .bus(psc_bus[g].psc)
        );
    end

    dpt_noise_filter u_nr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .enable_i(st_ff.cnt_mode & st_ff.func_sel),
        .fall_i(fall2048),
        .raw_i(event_input_i),
        .level_o(ev_lvl)
    );

    assign ev_edge = st_ff.polarity ? (ev_lvl & !st_ff.ev_prev) : (!ev_lvl & st_ff.ev_prev);
    assign level_ok = !st_ff.func_sel | (event_input_i == st_ff.polarity);
    assign tick0 = st_ff.cnt_mode ? ev_edge : (psc_tick[0] & level_ok);
    assign dec0 = st_ff.run[0] & tick0;
    assign uf0 = dec0 & (st_ff.count[0] == 8'h00);
    assign dec1 = st_ff.cascade ? uf0 : (st_ff.run[1] & psc_tick[1]);
    assign uf1 = dec1 & (st_ff.count[1] == 8'h00);
    assign out_uf = (st_ff.cascade | st_ff.output_channel_select) ? uf1 : uf0;

    always_comb begin
        case (idx)
            IDX_SHARED: rmux = {3'h0, st_ff.cascade, st_ff.output_channel_select, st_ff.oe, st_ff.src_sel};
            IDX_T0CTL: rmux = {st_ff.cnt_mode, st_ff.func_sel, st_ff.polarity, st_ff.div[0],
                               st_ff.cont[0], 1'b0, st_ff.run[0]};
            IDX_T1CTL: rmux = {3'h0, st_ff.div[1], st_ff.cont[1], 1'b0, st_ff.run[1]};
            IDX_RLD0: rmux = st_ff.reload[0];
            IDX_RLD1: rmux = st_ff.reload[1];
            IDX_CNT0: rmux = st_ff.readout[0];
            IDX_CNT1: rmux = st_ff.readout[1];
            IDX_FLAGS: rmux = {6'h00, st_ff.flag};
            default: rmux = 8'h00;
        endcase
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = req & !st_ff.ack;
        if (req & !st_ff.ack) begin
            nxt_st.rdat = rmux;
        end
        if (low_speed_osc_clock_i) begin
            nxt_st.ls_div = half_tick ? 4'h0 : st_ff.ls_div + 4'h1;
        end
        if (half_tick) begin
            nxt_st.sig2048 = !st_ff.sig2048;
        end
        nxt_st.ev_prev = ev_lvl;
        if (dec0) begin
            nxt_st.count[0] = uf0 ? st_ff.reload[0] : st_ff.count[0] - 8'h01;
        end
        if (dec1) begin
            nxt_st.count[1] = uf1 ? st_ff.reload[1] : st_ff.count[1] - 8'h01;
        end
        if (!st_ff.cascade) begin
            if (uf0 & !st_ff.cont[0]) begin
                nxt_st.run[0] = 1'b0;
            end
            if (uf1 & !st_ff.cont[1]) begin
                nxt_st.run[1] = 1'b0;
            end
        end else if (uf1 & !st_ff.cont[0]) begin
            nxt_st.run[0] = 1'b0;
        end
        nxt_st.readout[0] = st_ff.count[0];
        if (!st_ff.latched) begin
            nxt_st.readout[1] = st_ff.count[1];
        end
        if (st_ff.latched & half_tick) begin
            nxt_st.latch_age = st_ff.latch_age + 3'h1;
            if (st_ff.latch_age == LATCH_HALF_LAST) begin
                nxt_st.latched = 1'b0;
            end
        end
        if (!st_ff.cascade | (rd & idx == IDX_CNT1)) begin
            nxt_st.latched = 1'b0;
        end
        if (st_ff.cascade & rd & idx == IDX_CNT0) begin
            nxt_st.latched = 1'b1;
            nxt_st.latch_age = 3'h0;
        end
        if (wr) begin
            case (idx)
                IDX_SHARED: begin
                    nxt_st.src_sel = {wdat[SH_SRC1], wdat[SH_SRC0]};
                    nxt_st.oe = wdat[SH_OE];
                    nxt_st.output_channel_select = wdat[SH_OUTPUT_CHANNEL_SELECT];
                    nxt_st.cascade = wdat[SH_CASCADE];
                end
                IDX_T0CTL: begin
                    nxt_st.cnt_mode = wdat[CT_MODE];
                    nxt_st.func_sel = wdat[CT_FSEL];
                    nxt_st.polarity = wdat[CT_POL];
                    nxt_st.div[0] = wdat[CT_DIV_HI:CT_DIV_LO];
                    nxt_st.cont[0] = wdat[CT_CONT];
                    nxt_st.run[0] = wdat[CT_RUN];
                    if (wdat[CT_PRESET]) begin
                        nxt_st.count[0] = st_ff.reload[0];
                    end
                end
                IDX_T1CTL: begin
                    nxt_st.div[1] = wdat[CT_DIV_HI:CT_DIV_LO];
                    nxt_st.cont[1] = wdat[CT_CONT];
                    nxt_st.run[1] = wdat[CT_RUN];
                    if (wdat[CT_PRESET] & !st_ff.cascade) begin
                        nxt_st.count[1] = st_ff.reload[1];
                    end
                end
                IDX_RLD0: nxt_st.reload[0] = wdat;
                IDX_RLD1: nxt_st.reload[1] = wdat;
                // Clear first so that a same-cycle underflow still sets the flag
                IDX_FLAGS: nxt_st.flag = st_ff.flag & ~wdat[1:0];
                default: ;
            endcase
        end
        if (uf0 & !st_ff.cascade) begin
            nxt_st.flag[0] = 1'b1;
        end
        if (uf1) begin
            nxt_st.flag[1] = 1'b1;
        end
        if (nxt_st.cascade) begin
            nxt_st.run[1] = 1'b0;
        end
        if (out_uf) begin
            nxt_st.timer_output_signal = !st_ff.timer_output_signal;
        end
        nxt_st.pin = nxt_st.oe ? nxt_st.timer_output_signal : 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
            st_ff.reload <= {RELOAD_RST, RELOAD_RST};
            st_ff.count <= {COUNT_RST, COUNT_RST};
            st_ff.readout <= {COUNT_RST, COUNT_RST};
            st_ff.div <= {DIV_RST, DIV_RST};
            st_ff.pin <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign wb_ack_o = st_ff.ack;
    assign wb_dat_o = {24'h000000, st_ff.rdat};
    assign timer_output_port_pin_o = st_ff.pin;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

    property p_preset_reads_zero;
        wb_ack_o && !wb_we_i && idx == IDX_T0CTL |-> !wb_dat_o[CT_PRESET];
    endproperty
    a_preset_reads_zero: assert property (p_preset_reads_zero) else $error("preset read 1");

    property p_preset_stopped;
        wr && idx == IDX_T0CTL && wdat[CT_PRESET] && !wdat[CT_RUN]
            |=> st_ff.count[0] == $past(st_ff.reload[0]) ##1 $stable(st_ff.count[0]);
    endproperty
    a_preset_stopped: assert property (p_preset_stopped) else $error("preset not held");

    property p_cascade_run1;
        st_ff.cascade |=> !st_ff.run[1];
    endproperty
    a_cascade_run1: assert property (p_cascade_run1) else $error("timer1 runs in 16-bit");

    property p_oneshot_stop;
        uf0 && !st_ff.cascade && !st_ff.cont[0] && !(wr && idx == IDX_T0CTL)
            |=> !st_ff.run[0] && st_ff.count[0] == $past(st_ff.reload[0]);
    endproperty
    a_oneshot_stop: assert property (p_oneshot_stop) else $error("one-shot did not stop");

    property p_cont_reload;
        uf1 && !st_ff.cascade && st_ff.cont[1] && !(wr && idx == IDX_T1CTL)
            |=> st_ff.run[1] && st_ff.count[1] == $past(st_ff.reload[1]);
    endproperty
    a_cont_reload: assert property (p_cont_reload) else $error("continuous reload lost");

    property p_flag_set;
        uf0 && !st_ff.cascade |=> st_ff.flag[0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("timer0 flag not set");

    property p_pin_high;
        !st_ff.oe && !wr |=> timer_output_port_pin_o;
    endproperty
    a_pin_high: assert property (p_pin_high) else $error("pin not high when disabled");

    property p_stop_hold;
        !st_ff.run[0] && !wr |=> $stable(st_ff.count[0]);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stopped timer changed");

    property p_latch_hold;
        st_ff.latched && st_ff.cascade && !rd |=> $stable(st_ff.readout[1]);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched byte moved");

    property p_cascade_borrow;
        st_ff.cascade && uf0 && st_ff.count[1] != 8'h00 && !wr
            |=> st_ff.count[1] == $past(st_ff.count[1]) - 8'h01;
    endproperty
    a_cascade_borrow: assert property (p_cascade_borrow) else $error("borrow missed");
endmodule

// File: tb/dpt_event_src.sv
module dpt_event_src (
    input wire logic clk_i,
    output logic level_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle high, like a key input with a pull-up
    initial level_o = 1'b1;

    // Each level is held w clocks so slow and quick sources can both be played
    task automatic send(input int n, input int w);
        repeat (n) begin
            @(posedge clk_i);
            level_o <= ~level_o;
            repeat (w - 1) @(posedge clk_i);
        end
    endtask
endmodule

// File: tb/tb_top.sv
module tb_top import dpt_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [ADR_W-1:0] adr = '0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic ls_pulse = 1'b0;
    logic hs_pulse = 1'b0;
    logic evt;
    logic pin;
    int err_count = 0;
    int total_checks = 0;
    int m0;
    int m1;
    int r1;
    logic [7:0] rst_q[$] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00};

    always #12.5 clk_i = ~clk_i;

    dpt_top dpt_top_inst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(cyc),
        .wb_stb_i(stb),
        .wb_we_i(we),
        .wb_adr_i(adr),
        .wb_sel_i(sel),
        .wb_dat_i(wdat),
        .wb_dat_o(rdat),
        .wb_ack_o(ack),
        .low_speed_osc_clock_i(ls_pulse),
        .high_speed_osc_clock_i(hs_pulse),
        .event_input_i(evt),
        .timer_output_port_pin_o(pin)
    );

    dpt_event_src dpt_event_src_inst (
        .clk_i(clk_i),
        .level_o(evt)
    );

    task automatic conclude();
        if (err_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic [15:0] idx, input logic w, input logic [7:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'h0};
        sel <= 4'hF;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1);
        // Ack follows the request by exactly one cycle, so it is seen on the second edge
        chk(32'(n), 32'h2);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(idx, 1'b1, d, q);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        bus(idx, 1'b0, 8'h00, q);
        chk(q, exp);
    endtask

    task automatic osc(input logic hs, input int n);
        repeat (n) begin
            @(posedge clk_i);
            if (hs) hs_pulse <= 1'b1;
            else ls_pulse <= 1'b1;
            @(posedge clk_i);
            hs_pulse <= 1'b0;
            ls_pulse <= 1'b0;
        end
    endtask

    task automatic settle();
        repeat (3) @(posedge clk_i);
    endtask

    function automatic int nx(input int c, input int r);
        return (c == 0) ? r : c - 1;
    endfunction

    // Cascade model: timer1 steps only on a borrow out of timer0
    task automatic casc(input int n);
        repeat (n) begin
            if (m0 == 0) m1 = nx(m1, r1);
            m0 = nx(m0, 3);
        end
    endtask

    initial begin
        int r, k, dv, src, t, m, f, i;
        logic p;
        void'($urandom(37211));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 9; i++) begin
            rd(IDX_SHARED + 16'(i), {24'h0, rst_q[i]});
        end
        chk({31'h0, pin}, 32'h1);
        wr(IDX_CNT0, 8'h12);
        rd(IDX_CNT0, 32'hFF);
        wr(IDX_T0CTL, 8'hFE);
        rd(IDX_T0CTL, 32'hFC);
        wr(IDX_T1CTL, 8'hFE);
        rd(IDX_T1CTL, 32'h1C);
        wr(IDX_T0CTL, 8'h00);
        wr(IDX_T1CTL, 8'h00);
        for (t = 0; t < 2; t++) begin
            for (dv = 0; dv < 4; dv++) begin
                r = $urandom % 256;
                k = 1 + $urandom % 40;
                src = $urandom % 2;
                wr(IDX_SHARED, 8'(src << t));
                wr(IDX_RLD0 + 16'(t), 8'(r));
                wr(IDX_T0CTL + 16'(t), 8'h02);
                wr(IDX_FLAGS, 8'h03);
                wr(IDX_T0CTL + 16'(t), 8'(8'h05 | (dv << 3)));
                osc(src[0], k << (2 * dv));
                osc(~src[0], 5);
                wr(IDX_T0CTL + 16'(t), 8'(dv << 3));
                m = r;
                f = 0;
                repeat (k) begin
                    if (m == 0) f = 1;
                    m = nx(m, r);
                end
                rd(IDX_CNT0 + 16'(t), m);
                rd(IDX_FLAGS, f << t);
                wr(IDX_FLAGS, 8'h03);
                rd(IDX_FLAGS, 32'h0);
                wr(IDX_T0CTL + 16'(t), 8'(8'h05 | (dv << 3)));
                osc(src[0], 1 << (2 * dv));
                wr(IDX_T0CTL + 16'(t), 8'(dv << 3));
                rd(IDX_CNT0 + 16'(t), nx(m, r));
                settle();
                chk({31'h0, pin}, 32'h1);
            end
        end
        r = 3 + $urandom % 8;
        wr(IDX_RLD1, 8'(r));
        wr(IDX_T1CTL, 8'h02);
        wr(IDX_SHARED, 8'h0C);
        settle();
        p = pin;
        wr(IDX_T1CTL, 8'h01);
        osc(1'b0, r + 4);
        rd(IDX_T1CTL, 32'h0);
        rd(IDX_CNT1, r);
        wr(IDX_RLD1, 8'h55);
        rd(IDX_CNT1, r);
        settle();
        chk({31'h0, pin}, {31'h0, ~p});
        wr(IDX_RLD0, 8'h00);
        wr(IDX_T0CTL, 8'h02);
        wr(IDX_T0CTL, 8'h05);
        osc(1'b0, 3);
        settle();
        chk({31'h0, pin}, {31'h0, ~p});
        wr(IDX_SHARED, 8'h04);
        osc(1'b0, 3);
        settle();
        chk({31'h0, pin}, {31'h0, p});
        wr(IDX_T0CTL, 8'h00);
        // Odd toggle count leaves one more fall than rise, so polarity shows
        for (i = 0; i < 2; i++) begin
            k = 1 + $urandom % 20;
            wr(IDX_RLD0, 8'hFF);
            wr(IDX_T0CTL, 8'h02);
            wr(IDX_SHARED, 8'h01);
            wr(IDX_T0CTL, 8'(8'h9D | (i << 5)));
            osc(1'b1, 9);
            dpt_event_src_inst.send(2 * k + 1, 3);
            wr(IDX_T0CTL, 8'h80);
            rd(IDX_CNT0, 32'(254 - k + i));
            dpt_event_src_inst.send(1, 3);
        end
        for (i = 0; i < 2; i++) begin
            wr(IDX_RLD0, 8'hFF);
            wr(IDX_T0CTL, 8'h02);
            wr(IDX_SHARED, 8'h00);
            wr(IDX_T0CTL, 8'(8'h45 | (i << 5)));
            osc(1'b0, 6);
            dpt_event_src_inst.send(1, 3);
            osc(1'b0, 5);
            dpt_event_src_inst.send(1, 3);
            wr(IDX_T0CTL, 8'h00);
            rd(IDX_CNT0, 32'(250 - i));
        end
        // A three-clock glitch sees no 2,048 Hz fall, so only the long low level counts
        wr(IDX_RLD0, 8'hFF);
        wr(IDX_T0CTL, 8'h02);
        wr(IDX_T0CTL, 8'hC1);
        dpt_event_src_inst.send(2, 3);
        dpt_event_src_inst.send(1, 1);
        osc(1'b0, 40);
        dpt_event_src_inst.send(1, 1);
        osc(1'b0, 40);
        wr(IDX_T0CTL, 8'hC0);
        rd(IDX_CNT0, 32'hFE);
        r1 = $urandom % 256;
        wr(IDX_RLD1, 8'(r1));
        wr(IDX_T1CTL, 8'h02);
        wr(IDX_RLD0, 8'h03);
        wr(IDX_T0CTL, 8'h02);
        wr(IDX_SHARED, 8'h12);
        wr(IDX_T1CTL, 8'h03);
        rd(IDX_T1CTL, 32'h0);
        m0 = 3;
        m1 = r1;
        k = 10 + $urandom % 20;
        wr(IDX_T0CTL, 8'h05);
        osc(1'b0, k);
        wr(IDX_T0CTL, 8'h04);
        casc(k);
        rd(IDX_CNT0, m0);
        rd(IDX_CNT1, m1);
        r1 = (~r1) & 255;
        wr(IDX_RLD1, 8'(r1));
        wr(IDX_T1CTL, 8'h02);
        rd(IDX_CNT0, m0);
        rd(IDX_CNT1, m1);
        rd(IDX_CNT0, m0);
        wr(IDX_T0CTL, 8'h05);
        osc(1'b0, 4);
        wr(IDX_T0CTL, 8'h04);
        rd(IDX_CNT1, m1);
        casc(4);
        rd(IDX_CNT1, m1);
        rd(IDX_CNT0, m0);
        conclude();
    end

    initial begin
        repeat (90000) @(posedge clk_i);
        err_count++;
        conclude();
    end
endmodule
